// *** common/rsc_pkg.sv ***
package rsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SYNC = 8'h84;
    localparam logic [7:0] IDX_STORE = 8'h85;
    localparam logic [7:0] IDX_ERCFG = 8'h86;
    localparam logic [7:0] IDX_FIFO = 8'h87;
    localparam logic [7:0] IDX_IBUS = 8'h88;
    localparam logic [7:0] IDX_SPARE = 8'h89;
    localparam logic [7:0] IDX_XPORT = 8'h8A;
    localparam logic [7:0] IDX_STAT = 8'h8F;
    // writable bit masks; other bits read zero
    localparam logic [7:0] MASK_SYNC = 8'h07;
    localparam logic [7:0] MASK_STORE = 8'hDF;
    localparam logic [7:0] MASK_ERCFG = 8'hFF;
    localparam logic [7:0] MASK_FIFO = 8'h03;
    localparam logic [7:0] MASK_IBUS = 8'h7F;
    localparam logic [7:0] MASK_SPARE = 8'h07;
    localparam logic [7:0] MASK_XPORT = 8'h04;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int SY_TYPE = 0;
    localparam int SY_VARIANT = 1;
    localparam int SY_DIR = 2;
    localparam int ST_ON = 0;
    localparam int ST_MIN = 1;
    localparam int ST_RECENTRE = 2;
    localparam int ST_ALIGN = 3;
    localparam int ST_ZONE = 4;
    localparam int ST_GAP = 6;
    localparam int ST_FMT = 7;
    localparam int EC_LCV = 0;
    localparam int EC_MOS = 1;
    localparam int EC_FSB = 2;
    localparam int EC_ACC = 3;
    localparam int EC_PER = 4;
    localparam int EC_MAN = 5;
    localparam int EC_EXT = 6;
    localparam int EC_SHR = 7;
    localparam int IB_ON = 3;
    localparam int IB_TYPE = 4;
    localparam int XP_DIR = 2;
    // timing and sizes
    localparam logic [8:0] FRAMES_T1 = 9'd333;
    localparam logic [8:0] FRAMES_E1 = 9'd500;
    localparam logic [7:0] ZONE_WIDE = 8'd9;
    localparam logic [7:0] ZONE_NARROW = 8'd2;
    localparam logic [7:0] HALF_T1 = 8'd12;
    localparam logic [7:0] HALF_E1 = 8'd16;
    localparam logic [3:0] BITS_64K = 4'd8;
    localparam logic [3:0] BITS_56K = 4'd7;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] sync;
        logic [7:0] store;
        logic [7:0] ercfg;
        logic [7:0] fifo;
        logic [7:0] ibus;
        logic [7:0] spare;
        logic [7:0] xport;
    } rsc_regs_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_hold;
        logic w_hold;
        logic [7:0] aw_idx;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsc_axi_type;
endpackage

// *** src/rsc_top.sv ***
// Functional notes
// R1 - T1 frame mode: double-wide sync pulse in signaling frames when variant bit set.
// R2 - E1: variant bit picks CAS or CRC-4 multiframe, always on multiframe output.
// R3 - output pin gives frame pulses (type 0) or multiframe pulses (type 1).
// R4 - format bit: 64kbps all eight bits, or 56kbps seven bits.
// R5 - gapped clock bit drives gapped bit clock on channel clock output.
// R6 - during conversion force slip at 9 or 2 bytes separation or less.
// R7 - align rising edge recentres pointers only when closer than half frame.
// R8 - recentre rising edge moves read pointer; slips at once if in zone.
// R9 - store enable bypasses or uses store; depth two frames or 32 bits.
// R10 - timed updates may use the shared first-channel one-second timer.
// R11 - manual mode with external select latches on external latch rising edge.
// R12 - manual latch bit rising edge latches counters on next clock.
// R13 - automatic mode: once a second, or every 333 T1 / 500 E1 frames.
// R14 - accumulation bit selects automatic or manual counter updates.
// R15 - T1 path violation counter adds signaling framing bits when set.
// R16 - T1 multiframe counter counts bit errors or multiframes out of sync.
// R17 - line violation counter includes excessive zeros when set.
// R18 - watermark code selects 4, 16, 32 or 48 bytes.
// R19 - bus size code selects 2, 4 or 8 devices; code 11 reserved.
// R20 - interleave enable, channel or frame type, slot one to eight.
// R21 - spare code length 1 to 7 bits, code 111 means 8 or 16.
// R22 - BERT fed from receive framer or transmit path.
// R23 - sync pin output when 0, input only with store enabled.
// R24 - unassigned bits read zero; all registers zero after reset.
`timescale 1ns/1ns
`default_nettype none
module rsc_top #(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic t1_mode,
    input wire logic frame_start,
    input wire logic signaling_frame,
    input wire logic t1_mf_start,
    input wire logic cas_mf_start,
    input wire logic crc_mf_start,
    input wire logic receive_frame_sync_pin_i,
    output logic receive_frame_sync_pin_o,
    output logic receive_frame_sync_pin_oe,
    output logic receive_multiframe_sync_out,
    output logic sync_pin_frame_in,
    input wire logic normal_channel_clock,
    input wire logic gapped_bit_clock,
    output logic channel_clock_out,
    output logic [3:0] channel_bits_used,
    input wire logic rate_conversion,
    input wire logic [7:0] store_separation,
    output logic store_on,
    output logic store_min_delay,
    output logic store_slip_force,
    output logic store_align_pulse,
    output logic store_recentre_pulse,
    input wire logic own_second_tick,
    input wire logic shared_second_tick,
    input wire logic frame_tick,
    input wire logic external_counter_latch_in,
    output logic counter_latch,
    output logic signaling_fbit_report,
    output logic multiframe_counter_function,
    output logic violation_counter_function,
    output logic [5:0] fifo_watermark_bytes,
    output logic [3:0] interleave_devices,
    output logic interleave_on,
    output logic interleave_type_sel,
    output logic [2:0] bus_slot_position,
    output logic [3:0] spare_code_length,
    output logic spare_code_long,
    output logic bert_source_direction
);
    initial begin
        if (ADDR_W < 10) begin
            $error("ADDR_W must be at least 10");
        end
    end

    typedef struct packed {
        rsc_pkg::rsc_regs_type regs;
        rsc_pkg::rsc_axi_type axi;
        logic sync_o;
        logic sync_oe;
        logic sync_in;
        logic mf_o;
        logic wide_pend;
        logic chclk;
        logic [3:0] bits_used;
        logic slip;
        logic align;
        logic recentre;
        logic recentre_chk;
        logic latch;
        logic ext_prev;
        logic [8:0] frame_cnt;
        logic [7:0] latch_events;
        logic [5:0] wmark;
        logic [3:0] devices;
        logic [3:0] spare_len;
        logic spare_long;
    } rsc_state_type;

    rsc_state_type s;
    rsc_state_type next_s;

    logic [7:0] w_old;
    logic [7:0] w_new;
    logic [7:0] w_rise;
    logic [7:0] half;
    logic [7:0] zone;
    logic [8:0] frame_lim;
    logic pulse;
    logic sec_tick;
    logic timed_tick;
    logic do_write;
    logic [7:0] rd;
    logic rd_ok;

    always_comb begin
        next_s = s;
        w_old = 8'h00;
        w_new = 8'h00;
        w_rise = 8'h00;
        rd = 8'h00;
        rd_ok = 1'b1;
        // axi write channel
        if (s_axi_awvalid && s.axi.awready) begin
            next_s.axi.aw_hold = 1'b1;
            next_s.axi.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && s.axi.wready) begin
            next_s.axi.w_hold = 1'b1;
            next_s.axi.wdata = s_axi_wdata[7:0];
            next_s.axi.wstrb0 = s_axi_wstrb[0];
        end
        if (s.axi.bvalid && s_axi_bready) begin
            next_s.axi.bvalid = 1'b0;
        end
        do_write = s.axi.aw_hold && s.axi.w_hold && !s.axi.bvalid;
        if (do_write) begin
            next_s.axi.aw_hold = 1'b0;
            next_s.axi.w_hold = 1'b0;
            next_s.axi.bvalid = 1'b1;
            next_s.axi.bresp = rsc_pkg::RESP_OKAY;
            unique case (s.axi.aw_idx)
                rsc_pkg::IDX_SYNC: w_old = s.regs.sync;
                rsc_pkg::IDX_STORE: w_old = s.regs.store;
                rsc_pkg::IDX_ERCFG: w_old = s.regs.ercfg;
                rsc_pkg::IDX_FIFO: w_old = s.regs.fifo;
                rsc_pkg::IDX_IBUS: w_old = s.regs.ibus;
                rsc_pkg::IDX_SPARE: w_old = s.regs.spare;
                rsc_pkg::IDX_XPORT: w_old = s.regs.xport;
                rsc_pkg::IDX_STAT: w_old = 8'h00;
                default: next_s.axi.bresp = rsc_pkg::RESP_SLVERR;
            endcase
            w_new = s.axi.wstrb0 ? s.axi.wdata : w_old;
            unique case (s.axi.aw_idx)
                rsc_pkg::IDX_SYNC: next_s.regs.sync = w_new & rsc_pkg::MASK_SYNC; // [R24]
                rsc_pkg::IDX_STORE: next_s.regs.store = w_new & rsc_pkg::MASK_STORE;
                rsc_pkg::IDX_ERCFG: next_s.regs.ercfg = w_new & rsc_pkg::MASK_ERCFG;
                rsc_pkg::IDX_FIFO: next_s.regs.fifo = w_new & rsc_pkg::MASK_FIFO;
                rsc_pkg::IDX_IBUS: next_s.regs.ibus = w_new & rsc_pkg::MASK_IBUS;
                rsc_pkg::IDX_SPARE: next_s.regs.spare = w_new & rsc_pkg::MASK_SPARE;
                rsc_pkg::IDX_XPORT: next_s.regs.xport = w_new & rsc_pkg::MASK_XPORT;
                default: w_rise = 8'h00;
            endcase
            w_rise = w_new & ~w_old;
        end
        next_s.axi.awready = !next_s.axi.aw_hold && !next_s.axi.bvalid;
        next_s.axi.wready = !next_s.axi.w_hold && !next_s.axi.bvalid;
        // axi read channel
        if (s.axi.rvalid && s_axi_rready) begin
            next_s.axi.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.axi.arready) begin
            unique case (s_axi_araddr[9:2])
                rsc_pkg::IDX_SYNC: rd = s.regs.sync;
                rsc_pkg::IDX_STORE: rd = s.regs.store;
                rsc_pkg::IDX_ERCFG: rd = s.regs.ercfg;
                rsc_pkg::IDX_FIFO: rd = s.regs.fifo;
                rsc_pkg::IDX_IBUS: rd = s.regs.ibus;
                rsc_pkg::IDX_SPARE: rd = s.regs.spare;
                rsc_pkg::IDX_XPORT: rd = s.regs.xport;
                rsc_pkg::IDX_STAT: rd = s.latch_events;
                default: rd_ok = 1'b0;
            endcase
            next_s.axi.rvalid = 1'b1;
            next_s.axi.rdata = {24'h000000, rd};
            next_s.axi.rresp = rd_ok ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
        end
        next_s.axi.arready = !next_s.axi.rvalid;

        // frame sync output and multiframe output
        if (s.regs.sync[rsc_pkg::SY_TYPE]) begin // [R3]
            if (t1_mode) begin
                pulse = t1_mf_start;
            end else begin
                pulse = s.regs.sync[rsc_pkg::SY_VARIANT] ? crc_mf_start : cas_mf_start; // [R2]
            end
        end else begin
            pulse = frame_start;
        end
        next_s.wide_pend = 1'b0;
        if (t1_mode && !s.regs.sync[rsc_pkg::SY_TYPE] && s.regs.sync[rsc_pkg::SY_VARIANT]
            && signaling_frame && frame_start) begin
            next_s.wide_pend = 1'b1; // [R1]
        end
        next_s.sync_o = pulse || s.wide_pend; // [R1]
        if (t1_mode) begin
            next_s.mf_o = t1_mf_start;
        end else begin
            next_s.mf_o = s.regs.sync[rsc_pkg::SY_VARIANT] ? crc_mf_start : cas_mf_start; // [R2]
        end
        next_s.sync_oe = !(s.regs.sync[rsc_pkg::SY_DIR] && s.regs.store[rsc_pkg::ST_ON]); // [R23]
        next_s.sync_in = !next_s.sync_oe && receive_frame_sync_pin_i;

        // channel clock and format
        next_s.chclk = s.regs.store[rsc_pkg::ST_GAP] ? gapped_bit_clock : normal_channel_clock; // [R5]
        next_s.bits_used = s.regs.store[rsc_pkg::ST_FMT] ? rsc_pkg::BITS_56K : rsc_pkg::BITS_64K; // [R4]

        // elastic store commands
        half = t1_mode ? rsc_pkg::HALF_T1 : rsc_pkg::HALF_E1;
        zone = s.regs.store[rsc_pkg::ST_ZONE] ? rsc_pkg::ZONE_NARROW : rsc_pkg::ZONE_WIDE;
        next_s.align = do_write && s.axi.aw_idx == rsc_pkg::IDX_STORE && w_rise[rsc_pkg::ST_ALIGN]
            && s.regs.store[rsc_pkg::ST_ON] && store_separation < half; // [R7]
        next_s.recentre = do_write && s.axi.aw_idx == rsc_pkg::IDX_STORE
            && w_rise[rsc_pkg::ST_RECENTRE] && s.regs.store[rsc_pkg::ST_ON]; // [R8]
        next_s.recentre_chk = s.recentre;
        next_s.slip = s.regs.store[rsc_pkg::ST_ON] && store_separation <= zone
            && (rate_conversion || s.recentre_chk); // [R6] [R8]

        // counter update timing
        frame_lim = t1_mode ? rsc_pkg::FRAMES_T1 : rsc_pkg::FRAMES_E1;
        sec_tick = s.regs.ercfg[rsc_pkg::EC_SHR] ? shared_second_tick : own_second_tick; // [R10]
        timed_tick = 1'b0;
        if (frame_tick) begin
            if (s.frame_cnt >= frame_lim - 9'd1) begin
                next_s.frame_cnt = 9'd0;
                timed_tick = s.regs.ercfg[rsc_pkg::EC_PER]; // [R13]
            end else begin
                next_s.frame_cnt = s.frame_cnt + 9'd1;
            end
        end
        if (!s.regs.ercfg[rsc_pkg::EC_PER]) begin
            timed_tick = sec_tick; // [R13]
        end
        next_s.ext_prev = external_counter_latch_in;
        if (!s.regs.ercfg[rsc_pkg::EC_ACC]) begin // [R14]
            next_s.latch = timed_tick;
        end else if (s.regs.ercfg[rsc_pkg::EC_EXT]) begin
            next_s.latch = external_counter_latch_in && !s.ext_prev; // [R11]
        end else begin
            next_s.latch = do_write && s.axi.aw_idx == rsc_pkg::IDX_ERCFG
                && w_rise[rsc_pkg::EC_MAN]; // [R12]
        end
        if (s.latch) begin
            next_s.latch_events = s.latch_events + 8'd1;
        end

        // decoded configuration
        unique case (s.regs.fifo[1:0]) // [R18]
            2'b00: next_s.wmark = 6'd4;
            2'b01: next_s.wmark = 6'd16;
            2'b10: next_s.wmark = 6'd32;
            2'b11: next_s.wmark = 6'd48;
        endcase
        unique case (s.regs.ibus[6:5]) // [R19]
            2'b00: next_s.devices = 4'd2;
            2'b01: next_s.devices = 4'd4;
            2'b10: next_s.devices = 4'd8;
            2'b11: next_s.devices = 4'd0;
        endcase
        next_s.spare_long = &s.regs.spare[2:0]; // [R21]
        next_s.spare_len = next_s.spare_long ? 4'd8 : {1'b0, s.regs.spare[2:0]} + 4'd1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0; // [R24]
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.axi.awready;
    assign s_axi_wready = s.axi.wready;
    assign s_axi_bvalid = s.axi.bvalid;
    assign s_axi_bresp = s.axi.bresp;
    assign s_axi_arready = s.axi.arready;
    assign s_axi_rvalid = s.axi.rvalid;
    assign s_axi_rdata = s.axi.rdata;
    assign s_axi_rresp = s.axi.rresp;
    assign receive_frame_sync_pin_o = s.sync_o;
    assign receive_frame_sync_pin_oe = s.sync_oe;
    assign receive_multiframe_sync_out = s.mf_o;
    assign sync_pin_frame_in = s.sync_in;
    assign channel_clock_out = s.chclk;
    assign channel_bits_used = s.bits_used;
    assign store_on = s.regs.store[rsc_pkg::ST_ON]; // [R9]
    assign store_min_delay = s.regs.store[rsc_pkg::ST_MIN]; // [R9]
    assign store_slip_force = s.slip;
    assign store_align_pulse = s.align;
    assign store_recentre_pulse = s.recentre;
    assign counter_latch = s.latch;
    assign signaling_fbit_report = s.regs.ercfg[rsc_pkg::EC_FSB]; // [R15]
    assign multiframe_counter_function = s.regs.ercfg[rsc_pkg::EC_MOS]; // [R16]
    assign violation_counter_function = s.regs.ercfg[rsc_pkg::EC_LCV]; // [R17]
    assign fifo_watermark_bytes = s.wmark;
    assign interleave_devices = s.devices;
    assign interleave_on = s.regs.ibus[rsc_pkg::IB_ON]; // [R20]
    assign interleave_type_sel = s.regs.ibus[rsc_pkg::IB_TYPE]; // [R20]
    assign bus_slot_position = s.regs.ibus[2:0]; // [R20]
    assign spare_code_length = s.spare_len;
    assign spare_code_long = s.spare_long;
    assign bert_source_direction = s.regs.xport[rsc_pkg::XP_DIR]; // [R22]

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wide_start_s;
        t1_mode && frame_start && signaling_frame && !s.regs.sync[0] && s.regs.sync[1];
    endsequence

    double_wide_a: assert property (wide_start_s |-> ##1 receive_frame_sync_pin_o ##1 receive_frame_sync_pin_o) // [R1]
        else $error("double wide pulse missing");
    mf_out_sel_a: assert property (!t1_mode && s.regs.sync[1] && !$changed(s.regs.sync) |=> receive_multiframe_sync_out == $past(crc_mf_start)) // [R2]
        else $error("multiframe output source wrong");
    pulse_type_a: assert property (!s.regs.sync[0] && frame_start |=> receive_frame_sync_pin_o) // [R3]
        else $error("frame pulse missing");
    chan_format_a: assert property ($past(aresetn) && $stable(s.regs.store) // [R4]
        |-> channel_bits_used == (s.regs.store[7] ? 4'd7 : 4'd8))
        else $error("channel bit count wrong");
    gap_clock_a: assert property (s.regs.store[6] && $stable(s.regs.store) |=> channel_clock_out == $past(gapped_bit_clock)) // [R5]
        else $error("gapped clock not selected");
    slip_zone_a: assert property (rate_conversion && store_on && store_separation <= 8'd2 |=> store_slip_force) // [R6]
        else $error("slip not forced");
    align_far_a: assert property (store_align_pulse |-> $past(store_separation) < $past(half)) // [R7]
        else $error("align with wide separation");
    recentre_slip_a: assert property (store_recentre_pulse ##1 (store_on && store_separation <= 8'd2) |=> store_slip_force) // [R8]
        else $error("no slip after recentre");
    manual_latch_a: assert property (s.regs.ercfg[3] && !s.regs.ercfg[6] && $rose(s.regs.ercfg[5]) |-> counter_latch) // [R12]
        else $error("manual latch not on next clock");
    ext_latch_a: assert property (s.regs.ercfg[3] && s.regs.ercfg[6] && $rose(external_counter_latch_in) |=> counter_latch) // [R11]
        else $error("external latch missed");
    auto_sec_a: assert property (!s.regs.ercfg[3] && !s.regs.ercfg[4] && !s.regs.ercfg[7] && own_second_tick |=> counter_latch) // [R13]
        else $error("second update missed");
    watermark_a: assert property (s.regs.fifo[1:0] == 2'b11 && $stable(s.regs.fifo) |=> fifo_watermark_bytes == 6'd48) // [R18]
        else $error("watermark decode wrong");
endmodule
`default_nettype wire

// *** tb/rsc_top_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsc_top_bench;
    localparam logic [7:0] IX [7] = '{rsc_pkg::IDX_SYNC, rsc_pkg::IDX_STORE, rsc_pkg::IDX_ERCFG, rsc_pkg::IDX_FIFO,
        rsc_pkg::IDX_IBUS, rsc_pkg::IDX_SPARE, rsc_pkg::IDX_XPORT};
    localparam logic [7:0] MK [7] = '{rsc_pkg::MASK_SYNC, rsc_pkg::MASK_STORE, rsc_pkg::MASK_ERCFG, rsc_pkg::MASK_FIFO,
        rsc_pkg::MASK_IBUS, rsc_pkg::MASK_SPARE, rsc_pkg::MASK_XPORT};
    localparam int WMT [4] = '{4, 16, 32, 48};
    localparam int DEV [4] = '{2, 4, 8, 0};
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pv = 8'h00, store_separation = 8'hFF;
    logic t1_mode = 1'b1, receive_frame_sync_pin_i = 1'b0, normal_channel_clock = 1'b0, gapped_bit_clock = 1'b1;
    logic rate_conversion = 1'b0, external_counter_latch_in = 1'b0;
    wire logic frame_start, signaling_frame, t1_mf_start, cas_mf_start, crc_mf_start, own_second_tick;
    wire logic shared_second_tick, frame_tick;
    logic receive_frame_sync_pin_o, receive_frame_sync_pin_oe, receive_multiframe_sync_out, sync_pin_frame_in;
    logic channel_clock_out, store_on, store_min_delay, store_slip_force, store_align_pulse, store_recentre_pulse;
    logic counter_latch, signaling_fbit_report, multiframe_counter_function, violation_counter_function;
    logic interleave_on, interleave_type_sel, spare_code_long, bert_source_direction;
    logic [3:0] channel_bits_used, interleave_devices, spare_code_length;
    logic [5:0] fifo_watermark_bytes;
    logic [2:0] bus_slot_position;
    int err_count = 0, check_count = 0, n_sync = 0, n_ms = 0, n_lat = 0, n_al = 0, n_rc = 0, n_sl = 0;
    assign {frame_tick, shared_second_tick, own_second_tick, crc_mf_start, cas_mf_start, t1_mf_start, signaling_frame,
        frame_start} = pv;
    rsc_top i_rsc_top (.*);
    always #20 aclk = ~aclk;
    // cycles high of each pulse output
    always @(posedge aclk) begin
        n_sync += int'(receive_frame_sync_pin_o === 1'b1);
        n_ms += int'(receive_multiframe_sync_out === 1'b1);
        n_lat += int'(counter_latch === 1'b1);
        n_al += int'(store_align_pulse === 1'b1);
        n_rc += int'(store_recentre_pulse === 1'b1);
        n_sl += int'(store_slip_force === 1'b1);
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task settle;
        repeat (3) @(posedge aclk);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = rsc_pkg::RESP_OKAY);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a && w)) begin
            @(posedge aclk);
            a |= s_axi_awvalid & s_axi_awready;
            w |= s_axi_wvalid & s_axi_wready;
            s_axi_awvalid <= !a;
            s_axi_wvalid <= !w;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
        settle;
    endtask
    task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] r = rsc_pkg::RESP_OKAY);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, r);
        @(posedge aclk);
    endtask
    task pl(input logic [7:0] m, input int n = 1);
        repeat (n) begin
            pv <= m;
            @(posedge aclk);
            pv <= 8'h00;
            @(posedge aclk);
        end
        settle;
    endtask
    task end_sim;
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_regs;
        for (int i = 0; i < 7; i++) begin
            rd(IX[i], 32'h00000000);
            wr(IX[i], 8'hFF);
            rd(IX[i], {24'h000000, MK[i]});
            wr(IX[i], 8'h00);
        end
        rd(8'h80, 32'h00000000, rsc_pkg::RESP_SLVERR);
        wr(8'h80, 8'hFF, rsc_pkg::RESP_SLVERR);
    endtask
    task t_fields;
        for (int c = 0; c < 4; c++) begin
            wr(IX[3], 8'(c));
            chk(fifo_watermark_bytes, WMT[c]);
            wr(IX[4], {1'b0, c[1:0], c[0], 1'b1, c[1:0], c[0]});
            chk(interleave_devices, DEV[c]);
            chk({interleave_type_sel, interleave_on, bus_slot_position}, {c[0], 1'b1, c[1:0], c[0]});
        end
        for (int c = 0; c < 8; c++) begin
            wr(IX[5], 8'(c));
            chk({spare_code_long, spare_code_length}, (c == 7) ? 5'h18 : 5'(c + 1));
        end
        wr(IX[2], 8'h05);
        chk({signaling_fbit_report, multiframe_counter_function, violation_counter_function}, 3'h5);
        wr(IX[1], 8'hC3);
        chk({channel_bits_used, channel_clock_out, store_on, store_min_delay}, 7'h3F);
        wr(IX[1], 8'h00);
        chk({channel_bits_used, channel_clock_out, store_on, store_min_delay}, 7'h40);
        wr(IX[6], 8'h04);
        chk(bert_source_direction, 1'b1);
    endtask
    task t_sync;
        n_sync = 0;
        pl(8'h03);
        chk(n_sync, 1);
        wr(IX[0], 8'h02);
        n_sync = 0;
        pl(8'h03);
        chk(n_sync, 2);
        wr(IX[0], 8'h01);
        n_sync = 0;
        pl(8'h01);
        pl(8'h04);
        chk(n_sync, 1);
        t1_mode <= 1'b0;
        for (int v = 0; v < 2; v++) begin
            wr(IX[0], {6'h00, v[0], 1'b1});
            n_ms = 0;
            pl(v ? 8'h08 : 8'h10);
            pl(v ? 8'h10 : 8'h08);
            chk(n_ms, 1);
        end
        wr(IX[0], 8'h04);
        chk(receive_frame_sync_pin_oe, 1'b1);
        wr(IX[1], 8'h01);
        chk(receive_frame_sync_pin_oe, 1'b0);
        receive_frame_sync_pin_i <= 1'b1;
        settle;
        chk(sync_pin_frame_in, 1'b1);
        receive_frame_sync_pin_i <= 1'b0;
        t1_mode <= 1'b1;
    endtask
    task t_store;
        rate_conversion <= 1'b1;
        store_separation <= 8'h0A;
        settle;
        chk(store_slip_force, 1'b0);
        store_separation <= 8'h09;
        settle;
        chk(store_slip_force, 1'b1);
        wr(IX[1], 8'h11);
        chk(store_slip_force, 1'b0);
        store_separation <= 8'h02;
        settle;
        chk(store_slip_force, 1'b1);
        rate_conversion <= 1'b0;
        n_al = 0;
        wr(IX[1], 8'h09);
        wr(IX[1], 8'h09);
        chk(n_al, 1);
        store_separation <= 8'h14;
        wr(IX[1], 8'h01);
        wr(IX[1], 8'h09);
        chk(n_al, 1);
        n_rc = 0;
        wr(IX[1], 8'h05);
        chk(n_rc, 1);
        store_separation <= 8'h02;
        n_sl = 0;
        wr(IX[1], 8'h01);
        wr(IX[1], 8'h05);
        chk(n_sl, 1);
        wr(IX[1], 8'h00);
    endtask
    task t_count;
        n_lat = 0;
        wr(IX[2], 8'h08);
        wr(IX[2], 8'h28);
        pl(8'h20);
        chk(n_lat, 1);
        wr(IX[2], 8'h48);
        external_counter_latch_in <= 1'b1;
        settle;
        wr(IX[2], 8'h68);
        chk(n_lat, 2);
        external_counter_latch_in <= 1'b0;
        wr(IX[2], 8'h00);
        pl(8'h20);
        pl(8'h40);
        chk(n_lat, 3);
        wr(IX[2], 8'h80);
        pl(8'h20);
        pl(8'h40);
        chk(n_lat, 4);
        wr(IX[2], 8'h10);
        pl(8'h80, 332);
        chk(n_lat, 4);
        pl(8'h80);
        chk(n_lat, 5);
        t1_mode <= 1'b0;
        pl(8'h80, 499);
        chk(n_lat, 5);
        pl(8'h80);
        chk(n_lat, 6);
        rd(rsc_pkg::IDX_STAT, 32'h00000006);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_fields;
        t_sync;
        t_store;
        t_count;
        end_sim;
    end
    initial begin
        #800000;
        err_count++;
        end_sim;
    end
endmodule
`default_nettype wire
